// ---- bench/test_vector_magnitude_ref_debounce_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_vector_magnitude_ref_debounce_regs;
    import vm_regs_pkg::*;
    logic       clk_sys, rst, reg_wr, reg_rd, reg_hit, sample_tick, temp_enable;
    logic       func_enable, init_mode, update_mode, debounce_mode, above_thresh;
    logic       debounce_step, event_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, debounce_timer;
    logic [1:0] full_scale_range, ref_scale;
    sample_t    sample_x, sample_y, sample_z, ref_x, ref_y, ref_z;
    int         fails, cmp_count;
    logic [7:0] vals [7] = '{8'ha5, 8'he5, 8'h34, 8'h1a, 8'hc3, 8'h3f, 8'hff};

    vm_debounce_regs i_vm_debounce_regs (.clk_sys, .rst, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_hit, .sample_tick, .temp_enable, .func_enable,
        .init_mode, .update_mode, .debounce_mode, .above_thresh, .full_scale_range,
        .sample_x, .sample_y, .sample_z, .ref_x, .ref_y, .ref_z, .ref_scale,
        .debounce_step, .debounce_timer, .event_active);
    vm_host_model i_vm_host_model (.clk_sys, .reg_rdata, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata);

    // 10 MHz clock
    initial clk_sys = 1'b0;
    always #50 clk_sys = ~clk_sys;

    // Verdict and end of run
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Value compare
    task automatic check_val(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Read and compare one register
    task automatic rd_chk(input string what, input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic       hit_exp;
        hit_exp = addr >= OFS_DEBOUNCE_COUNT && addr <= OFS_REF_Z_LOW;
        fork
            i_vm_host_model.read(addr, d);
            begin
                @(posedge clk_sys);
                #10;
                check_val("address hit", {15'h0, hit_exp}, {15'h0, reg_hit});
            end
        join
        check_val(what, {8'h00, exp}, {8'h00, d});
    endtask
    // Reference from a high/low pair, sign bit 13
    function automatic logic [15:0] sext(input logic [7:0] h, input logic [7:0] l);
        return {{2{h[5]}}, h[5:0], l};
    endfunction
    // One output sample; checks the advance pulse
    task automatic tick(input logic exp_step);
        @(posedge clk_sys);
        #1;
        sample_tick = 1'b1;
        #10;
        check_val("debounce step", {15'h0, exp_step}, {15'h0, debounce_step});
        @(posedge clk_sys);
        #1;
        sample_tick = 1'b0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    task automatic test_reset_values();
        for (int a = 8'h62; a <= 8'h68; a++) begin
            rd_chk("reset value", 8'(a), RESET_VALUE);
        end
        rd_chk("unmapped read", 8'h69, 8'h00);
        $display("test reset_values done");
    endtask
    task automatic test_rw();
        for (int i = 0; i < 7; i++) i_vm_host_model.write(8'(8'h62 + i), vals[i]);
        i_vm_host_model.write(8'h69, 8'h55);
        for (int i = 0; i < 7; i++) begin
            rd_chk("readback", 8'(8'h62 + i), vals[i]);
        end
        rd_chk("unmapped write", 8'h69, 8'h00);
        $display("test rw done");
    endtask
    task automatic test_init_ref();
        init_mode   = 1'b1;
        func_enable = 1'b1;
        wait_cyc(2);
        check_val("ref x", sext(vals[1], vals[2]), ref_x);
        check_val("ref y", sext(vals[3], vals[4]), ref_y);
        check_val("ref z", sext(vals[5], vals[6]), ref_z);
        for (int f = 0; f < 4; f++) begin
            wait_cyc(1);
            full_scale_range = 2'(f);
            #10;
            check_val("ref scale", 16'(f), {14'h0, ref_scale});
        end
        $display("test init_ref done");
    endtask
    task automatic test_sample_ref();
        func_enable = 1'b0;
        wait_cyc(1);
        init_mode   = 1'b0;
        sample_x    = 16'h1234;
        sample_y    = 16'hfedc;
        sample_z    = 16'h0042;
        func_enable = 1'b1;
        wait_cyc(2);
        check_val("sample ref x", 16'h1234, ref_x);
        check_val("sample ref y", 16'hfedc, ref_y);
        check_val("sample ref z", 16'h0042, ref_z);
        $display("test sample_ref done");
    endtask
    task automatic test_live_update();
        func_enable = 1'b0;
        wait_cyc(1);
        init_mode   = 1'b1;
        update_mode = 1'b1;
        func_enable = 1'b1;
        i_vm_host_model.write(8'h64, 8'h77);
        i_vm_host_model.write(8'h65, 8'h3e);
        wait_cyc(1);
        check_val("live ref x", sext(vals[1], 8'h77), ref_x);
        check_val("live ref y", sext(8'h3e, vals[4]), ref_y);
        $display("test live_update done");
    endtask
    task automatic test_debounce();
        i_vm_host_model.write(8'h62, 8'h03);
        update_mode  = 1'b0;
        above_thresh = 1'b1;
        for (int i = 1; i <= 3; i++) begin
            tick(1'b1);
            check_val("timer up", 16'(i), {8'h0, debounce_timer});
            check_val("event", {15'h0, i == 3}, {15'h0, event_active});
        end
        tick(1'b1);
        check_val("timer saturate", 16'h3, {8'h0, debounce_timer});
        check_val("retrigger ref x", 16'h1234, ref_x);
        above_thresh = 1'b0;
        tick(1'b1);
        check_val("timer decrement", 16'h2, {8'h0, debounce_timer});
        debounce_mode = 1'b1;
        tick(1'b1);
        check_val("timer clear", 16'h0, {8'h0, debounce_timer});
        $display("test debounce done");
    endtask
    task automatic test_temp_rate();
        temp_enable  = 1'b1;
        above_thresh = 1'b1;
        for (int i = 0; i < 4; i++) tick(1'(i % 2));
        check_val("half rate timer", 16'h2, {8'h0, debounce_timer});
        temp_enable = 1'b0;
        $display("test temp_rate done");
    endtask
    task automatic test_mid_reset();
        rst = 1'b1;
        wait_cyc(2);
        rst = 1'b0;
        check_val("timer after reset", 16'h0, {8'h0, debounce_timer});
        rd_chk("count after reset", OFS_DEBOUNCE_COUNT, RESET_VALUE);
        rd_chk("x low after reset", OFS_REF_X_LOW, RESET_VALUE);
        $display("test mid_reset done");
    endtask

    // Watchdog
    initial begin
        wait_cyc(3000);
        fails++;
        complete_run();
    end
    // Main sequence
    initial begin
        {rst, sample_tick, temp_enable, func_enable, init_mode} = 5'b10000;
        {update_mode, debounce_mode, above_thresh, full_scale_range} = 5'b00000;
        {sample_x, sample_y, sample_z} = '0;
        fails     = 0;
        cmp_count = 0;
        wait_cyc(10);
        rst = 1'b0;
        test_reset_values();
        test_rw();
        test_init_ref();
        test_sample_ref();
        test_live_update();
        test_debounce();
        test_temp_rate();
        test_mid_reset();
        complete_run();
    end
endmodule
`default_nettype wire

// ---- bench/vm_host_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host register port model
// ****************************************
module vm_host_model (
    input  wire logic       clk_sys,   // System clock
    input  wire logic [7:0] reg_rdata, // Read data from bank
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    output logic      [7:0] reg_addr,  // Address
    output logic      [7:0] reg_wdata  // Write data
);
    // Quiet bus at time zero
    initial begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end
    // One write; also retargets a live reference in init plus update mode
    task automatic write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b1;
        reg_addr  = addr;
        reg_wdata = data;
        @(posedge clk_sys);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~addr; // Released lines lose last value
        reg_wdata = ~data;
    endtask
    // One read; data registered at the strobe edge
    task automatic read(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        #1;
        reg_rd   = 1'b1;
        reg_addr = addr;
        @(posedge clk_sys);
        #1;
        data     = reg_rdata;
        reg_rd   = 1'b0;
        reg_addr = ~addr;
    endtask
endmodule
`default_nettype wire

// ---- verilog/vm_debounce_regs.sv ----
`timescale 1ns/100ps
`default_nettype none
// Contract
// (R1) 8-bit debounce count register at 0x62
// (R2) Debounce steps once per output sample
// (R3) Temperature enable halves effective sample rate
// (R4) X reference: high 0x63[5:0], low 0x64
// (R5) Y reference: high 0x65[5:0], low 0x66
// (R6) Z reference: high 0x67[5:0], low 0x68
// (R7) Stored values used only when init mode
// (R8) Reference scale equals output sample scale
// (R9) Low byte holds reference bits 7:0
// (R10) Below threshold: decrement or clear counter
// (R11) Enable loads reference from samples or registers
// (R12) Init plus update mode: writes retarget live
// (R13) Sign bit 13, extend, ignore bits 7:6
module vm_debounce_regs (
    input  wire logic                  clk_sys,     // System clock 10 MHz
    input  wire logic                  rst,         // Sync reset, high
    input  wire logic                  reg_wr,      // Register write strobe
    input  wire logic                  reg_rd,      // Register read strobe
    input  wire logic [7:0]            reg_addr,    // Register address
    input  wire logic [7:0]            reg_wdata,   // Write data
    output logic      [7:0]            reg_rdata,   // Read data, registered
    output logic                       reg_hit,     // Address in this bank
    input  wire logic                  sample_tick, // One pulse per output sample
    input  wire logic                  temp_enable, // Temperature output enabled
    input  wire logic                  func_enable, // Vector-magnitude enable
    input  wire logic                  init_mode,   // Reference from stored registers
    input  wire logic                  update_mode, // Keep reference after trigger
    input  wire logic                  debounce_mode, // 1 clear, 0 decrement
    input  wire logic                  above_thresh,  // Magnitude above threshold
    input  wire logic [1:0]            full_scale_range, // Output scale setting
    input  wire vm_regs_pkg::sample_t  sample_x,    // Current X output
    input  wire vm_regs_pkg::sample_t  sample_y,    // Current Y output
    input  wire vm_regs_pkg::sample_t  sample_z,    // Current Z output
    output vm_regs_pkg::sample_t       ref_x,       // Active X reference
    output vm_regs_pkg::sample_t       ref_y,       // Active Y reference
    output vm_regs_pkg::sample_t       ref_z,       // Active Z reference
    output logic [1:0]                 ref_scale,   // Scale of reference LSB
    output logic                       debounce_step, // Debounce advance pulse
    output logic [7:0]                 debounce_timer, // Debounce counter
    output logic                       event_active // Count reached
);
    import vm_regs_pkg::*;

    // ****************************************
    // Register bank
    // ****************************************
    vm_ref_if      link [AXES] ();
    sample_t       stored [AXES];
    logic [7:0]    count_q;
    logic [7:0]    next_count;
    logic [7:0]    next_rdata;
    logic [7:0]    rdata_q;

    // Write strobes per axis
    assign link[0].wr_high = reg_wr && reg_addr == OFS_REF_X_HIGH; // [R4]
    assign link[0].wr_low  = reg_wr && reg_addr == OFS_REF_X_LOW;  // [R4]
    assign link[1].wr_high = reg_wr && reg_addr == OFS_REF_Y_HIGH; // [R5]
    assign link[1].wr_low  = reg_wr && reg_addr == OFS_REF_Y_LOW;  // [R5]
    assign link[2].wr_high = reg_wr && reg_addr == OFS_REF_Z_HIGH; // [R6]
    assign link[2].wr_low  = reg_wr && reg_addr == OFS_REF_Z_LOW;  // [R6]

    // Axis slices
    for (genvar i = 0; i < AXES; i++) begin : g_axis
        assign link[i].wdata = reg_wdata;
        vm_ref_axis u_axis (
            .clk_sys (clk_sys),
            .rst     (rst),
            .port    (link[i]),
            .ref_ext (stored[i])
        );
    end

    // Address decode
    assign reg_hit = reg_addr >= OFS_DEBOUNCE_COUNT && reg_addr <= OFS_REF_Z_LOW;

    // Count write and read mux
    always_comb begin
        next_count = count_q;
        if (reg_wr && reg_addr == OFS_DEBOUNCE_COUNT) begin
            next_count = reg_wdata; // [R1]
        end
        next_rdata = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_DEBOUNCE_COUNT: next_rdata = count_q; // [R1]
                OFS_REF_X_HIGH:     next_rdata = link[0].high_byte;
                OFS_REF_X_LOW:      next_rdata = link[0].low_byte;
                OFS_REF_Y_HIGH:     next_rdata = link[1].high_byte;
                OFS_REF_Y_LOW:      next_rdata = link[1].low_byte;
                OFS_REF_Z_HIGH:     next_rdata = link[2].high_byte;
                OFS_REF_Z_LOW:      next_rdata = link[2].low_byte;
                default:            next_rdata = 8'h00;
            endcase
        end
    end

    // Bank registers
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            count_q <= RESET_VALUE;
            rdata_q <= RESET_VALUE;
        end else begin
            count_q <= next_count;
            rdata_q <= next_rdata;
        end
    end
    assign reg_rdata = rdata_q;

    // ****************************************
    // Effective sample rate
    // ****************************************
    logic half_q;
    logic next_half;

    // Skip every other sample when temperature output is on
    always_comb begin
        next_half = half_q;
        if (!temp_enable) begin
            next_half = 1'b0;
        end else if (sample_tick) begin
            next_half = ~half_q; // [R3]
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            half_q <= 1'b0;
        end else begin
            half_q <= next_half;
        end
    end
    assign debounce_step = sample_tick && (!temp_enable || half_q); // [R2] [R3]

    // ****************************************
    // Debounce timer
    // ****************************************
    logic [7:0] timer_q;
    logic [7:0] next_timer;

    // Count up while above, decrement or clear while below
    always_comb begin
        next_timer = timer_q;
        if (!func_enable) begin
            next_timer = 8'h00;
        end else if (debounce_step) begin
            if (above_thresh) begin
                if (timer_q < count_q) begin
                    next_timer = timer_q + 8'h01; // [R2]
                end
            end else if (debounce_mode) begin
                next_timer = 8'h00; // [R10]
            end else if (timer_q != 8'h00) begin
                next_timer = timer_q - 8'h01; // [R10]
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            timer_q <= 8'h00;
        end else begin
            timer_q <= next_timer;
        end
    end
    assign debounce_timer = timer_q;
    assign event_active   = func_enable && above_thresh && timer_q >= count_q;

    // ****************************************
    // Reference vector
    // ****************************************
    vm_state_t state;
    vm_state_t next_state;
    sample_t   rx_q;
    sample_t   ry_q;
    sample_t   rz_q;
    sample_t   next_rx;
    sample_t   next_ry;
    sample_t   next_rz;
    logic      trig_q;
    logic      next_trig;
    logic      any_ref_wr;

    assign any_ref_wr = reg_wr && reg_addr >= OFS_REF_X_HIGH && reg_addr <= OFS_REF_Z_LOW;

    // Load, update and live retarget
    always_comb begin
        next_state = state;
        next_rx    = rx_q;
        next_ry    = ry_q;
        next_rz    = rz_q;
        next_trig  = event_active;
        unique case (state)
            ST_IDLE: begin
                if (func_enable) begin
                    next_state = ST_ARMED;
                    if (init_mode) begin
                        next_rx = stored[0]; // [R11] [R7]
                        next_ry = stored[1];
                        next_rz = stored[2];
                    end else begin
                        next_rx = sample_x;  // [R11]
                        next_ry = sample_y;
                        next_rz = sample_z;
                    end
                end
            end
            ST_ARMED: begin
                if (!func_enable) begin
                    next_state = ST_IDLE;
                end else if (init_mode && update_mode) begin
                    next_rx = stored[0]; // [R12]
                    next_ry = stored[1];
                    next_rz = stored[2];
                end else if (!update_mode && event_active && !trig_q) begin
                    next_rx = sample_x;
                    next_ry = sample_y;
                    next_rz = sample_z;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state  <= ST_IDLE;
            rx_q   <= '0;
            ry_q   <= '0;
            rz_q   <= '0;
            trig_q <= 1'b0;
        end else begin
            state  <= next_state;
            rx_q   <= next_rx;
            ry_q   <= next_ry;
            rz_q   <= next_rz;
            trig_q <= next_trig;
        end
    end
    assign ref_x     = rx_q;
    assign ref_y     = ry_q;
    assign ref_z     = rz_q;
    assign ref_scale = full_scale_range; // [R8]

    // ****************************************
    // Checks
    // ****************************************
    property p_count_write;
        @(posedge clk_sys) disable iff (rst)
        reg_wr && reg_addr == OFS_DEBOUNCE_COUNT |=> count_q == $past(reg_wdata);
    endproperty
    a_count_write: assert property (p_count_write) else $error("count write lost"); // [R1]

    property p_count_read;
        @(posedge clk_sys) disable iff (rst)
        reg_rd && reg_addr == OFS_DEBOUNCE_COUNT |=> reg_rdata == $past(count_q);
    endproperty
    a_count_read: assert property (p_count_read) else $error("count read wrong"); // [R1]

    property p_step_normal;
        @(posedge clk_sys) disable iff (rst)
        !temp_enable |-> debounce_step == sample_tick;
    endproperty
    a_step_normal: assert property (p_step_normal) else $error("step not per sample"); // [R2]

    property p_step_half;
        @(posedge clk_sys) disable iff (rst)
        temp_enable && debounce_step ##1 temp_enable[*1] |-> !debounce_step;
    endproperty
    a_step_half: assert property (p_step_half) else $error("step back to back"); // [R3]

    property p_clear_mode;
        @(posedge clk_sys) disable iff (rst)
        func_enable && debounce_step && !above_thresh && debounce_mode |=> timer_q == 8'h00;
    endproperty
    a_clear_mode: assert property (p_clear_mode) else $error("timer not cleared"); // [R10]

    property p_dec_mode;
        @(posedge clk_sys) disable iff (rst)
        func_enable && debounce_step && !above_thresh && !debounce_mode && timer_q != 8'h00
        |=> timer_q == $past(timer_q) - 8'h01;
    endproperty
    a_dec_mode: assert property (p_dec_mode) else $error("timer not decremented"); // [R10]

    property p_init_load;
        @(posedge clk_sys) disable iff (rst)
        state == ST_IDLE && func_enable && init_mode |=> rx_q == $past(stored[0]);
    endproperty
    a_init_load: assert property (p_init_load) else $error("stored ref not loaded"); // [R11]

    property p_sample_load;
        @(posedge clk_sys) disable iff (rst)
        state == ST_IDLE && func_enable && !init_mode |=> ry_q == $past(sample_y);
    endproperty
    a_sample_load: assert property (p_sample_load) else $error("sample ref not loaded"); // [R7]

    property p_live_update;
        @(posedge clk_sys) disable iff (rst)
        state == ST_ARMED && func_enable && init_mode && update_mode && any_ref_wr
        ##1 func_enable |=> rz_q == $past(stored[2]);
    endproperty
    a_live_update: assert property (p_live_update) else $error("live update missed"); // [R12]

    property p_sign_ext;
        @(posedge clk_sys) disable iff (rst)
        link[0].wr_high ##1 1'b1 |-> stored[0][15] == link[0].high_byte[5];
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign not extended"); // [R13]

    c_enable_init: cover property (@(posedge clk_sys) state == ST_IDLE && func_enable && init_mode);
    c_event:       cover property (@(posedge clk_sys) event_active && count_q != 8'h00);
    c_half_rate:   cover property (@(posedge clk_sys) temp_enable && debounce_step);
    c_live:        cover property (@(posedge clk_sys) state == ST_ARMED && update_mode && any_ref_wr);
    c_retrigger:   cover property (@(posedge clk_sys) state == ST_ARMED && !update_mode && event_active && !trig_q);
endmodule
`default_nettype wire

// ---- verilog/vm_ref_axis.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// One axis initial reference register pair
// ****************************************
module vm_ref_axis (
    input  wire logic         clk_sys, // System clock
    input  wire logic         rst,     // Sync reset
    vm_ref_if.slice           port,    // Register link
    output logic signed [15:0] ref_ext  // Sign-extended reference
);
    import vm_regs_pkg::*;
    logic [7:0] high_q;
    logic [7:0] low_q;
    logic [7:0] next_high;
    logic [7:0] next_low;

    // Next values of the byte pair
    always_comb begin
        next_high = high_q;
        next_low  = low_q;
        if (port.wr_high) begin
            next_high = port.wdata;
        end
        if (port.wr_low) begin
            next_low = port.wdata; // [R9]
        end
    end

    // Byte storage
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            high_q <= RESET_VALUE;
            low_q  <= RESET_VALUE;
        end else begin
            high_q <= next_high;
            low_q  <= next_low;
        end
    end

    assign port.high_byte = high_q;
    assign port.low_byte  = low_q;
    // Bit 13 is sign, bits 7:6 of high byte ignored
    assign ref_ext = {{2{high_q[HIGH_FIELD_MSB]}}, high_q[HIGH_FIELD_MSB:0], low_q}; // [R13] [R4]
endmodule
`default_nettype wire

// ---- verilog/vm_ref_if.sv ----
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Axis register link between bank and slices
// ****************************************
interface vm_ref_if;
    logic       wr_high;   // High byte written
    logic       wr_low;    // Low byte written
    logic [7:0] wdata;     // Write data
    logic [7:0] high_byte; // Stored high byte
    logic [7:0] low_byte;  // Stored low byte
    modport bank  (output wr_high, output wr_low, output wdata, input high_byte, input low_byte);
    modport slice (input wr_high, input wr_low, input wdata, output high_byte, output low_byte);
endinterface
`default_nettype wire

// ---- verilog/vm_regs_pkg.sv ----
`default_nettype none
package vm_regs_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] OFS_DEBOUNCE_COUNT = 8'h62;
    localparam logic [7:0] OFS_REF_X_HIGH     = 8'h63;
    localparam logic [7:0] OFS_REF_X_LOW      = 8'h64;
    localparam logic [7:0] OFS_REF_Y_HIGH     = 8'h65;
    localparam logic [7:0] OFS_REF_Y_LOW      = 8'h66;
    localparam logic [7:0] OFS_REF_Z_HIGH     = 8'h67;
    localparam logic [7:0] OFS_REF_Z_LOW      = 8'h68;
    localparam logic [7:0] RESET_VALUE        = 8'h00;
    localparam int         REF_WIDTH          = 14;
    localparam int         HIGH_FIELD_MSB     = 5;
    localparam int         SAMPLE_WIDTH       = 16;
    localparam int         AXES               = 3;
    // Per-axis index: 0 x, 1 y, 2 z
    typedef logic signed [REF_WIDTH-1:0]    ref_t;
    typedef logic signed [SAMPLE_WIDTH-1:0] sample_t;
    typedef enum logic [1:0] {ST_IDLE, ST_ARMED} vm_state_t;
endpackage
`default_nettype wire
